// file: pfu_cpu_map.sv
`timescale 1ns/100ps
module pfu_cpu_map (
  // mode and cpu address
  input  wire pfu_pkg::pfu_fmt_t fmt,
  input  wire logic [15:0]       cpu_addr,
  input  wire logic [7:0]        page_off,
  // plane settings
  input  wire logic [3:0]        plane_mask,
  input  wire logic [1:0]        rd_plane,
  // mapped access
  output logic [19:0]            word_addr,
  output logic [3:0]             lane_en,
  output logic [1:0]             rd_lane
);
  import pfu_pkg::*;

  logic [19:0] disp;

  // 4K page granularity: offset overlaps the top four cpu bits
  assign disp = {4'h0, cpu_addr} + {page_off, 12'h000};

  always_comb begin
    if (fmt == PFU_PLANAR4) begin
      word_addr = disp;
      lane_en   = plane_mask;
      rd_lane   = rd_plane;
    end else begin
      // low byte bits pick the plane, the rest the word
      word_addr = {2'b00, disp[19:2]};
      lane_en   = 4'(4'h1 << disp[1:0]);
      rd_lane   = disp[1:0];
    end
  end

endmodule : pfu_cpu_map

// file: pfu_mem_model.sv
`timescale 1ns/100ps
module pfu_mem_model (
  // clock and fetch delay
  input  wire logic        clk_sys,
  input  wire logic [1:0]  lag,
  // cpu port
  input  wire logic        cmem_req,
  input  wire logic        cmem_we,
  input  wire logic [19:0] cmem_addr,
  input  wire logic [3:0]  cmem_be,
  input  wire logic [31:0] cmem_wdata,
  output logic             cmem_ack,
  output logic [31:0]      cmem_rdata,
  // fetch port
  input  wire logic        dmem_req,
  input  wire logic [19:0] dmem_addr,
  output logic             dmem_ack,
  output logic [31:0]      dmem_rdata
);
  // only 1K bytes modelled; word address bits above 7 alias
  logic [31:0] mem [0:255];
  logic [1:0]  dw_r = 2'h0;

  initial begin
    cmem_ack = 1'b0;
    dmem_ack = 1'b0;
    cmem_rdata = 32'h0;
    dmem_rdata = 32'h0;
  end

  ////////////////////////////////////////
  // data turns to junk outside the ack cycle
  always @(posedge clk_sys) begin
    cmem_ack <= 1'b0;
    cmem_rdata <= ~cmem_rdata;
    if (cmem_req && !cmem_ack) begin
      cmem_ack <= 1'b1;
      if (cmem_we) begin
        for (int i = 0; i < 4; i++) begin
          if (cmem_be[i]) mem[cmem_addr[7:0]][8*i+:8] <= cmem_wdata[8*i+:8];
        end
      end else begin
        cmem_rdata <= mem[cmem_addr[7:0]];
      end
    end
  end

  always @(posedge clk_sys) begin
    dmem_ack <= 1'b0;
    dmem_rdata <= ~dmem_rdata;
    if (dmem_req && !dmem_ack) begin
      if (dw_r >= lag) begin
        dmem_ack <= 1'b1;
        dmem_rdata <= mem[dmem_addr[7:0]];
        dw_r <= 2'h0;
      end else begin
        dw_r <= dw_r + 2'h1;
      end
    end
  end
endmodule : pfu_mem_model

// file: pfu_pix_decode.sv
`timescale 1ns/100ps
module pfu_pix_decode (
  // format and raw pixel
  input  wire pfu_pkg::pfu_fmt_t fmt,
  input  wire logic [23:0]       raw,
  input  wire logic [3:0]        nib,
  // towards the dac
  output logic [7:0]             lut_idx,
  output logic [23:0]            rgb,
  output logic                   direct
);
  import pfu_pkg::*;

  logic [15:0] w;

  assign w = raw[15:0];

  // expands 5-5-5 into 8-8-8, low bits zero
  function automatic logic [23:0] pfu_exp555(input logic [14:0] v);
    pfu_exp555 = {v[PFU_R5_LSB +: 5], 3'h0, v[PFU_G5_LSB +: 5], 3'h0, v[PFU_B_LSB +: 5], 3'h0};
  endfunction : pfu_exp555

  always_comb begin
    lut_idx = 8'h00;
    rgb     = 24'h000000;
    direct  = 1'b0;
    unique case (fmt)
      PFU_PLANAR4: begin
        lut_idx = {4'h0, nib};
      end
      PFU_PACKED8: begin
        lut_idx = raw[7:0];
      end
      PFU_RGB555: begin
        rgb    = pfu_exp555(w[14:0]);
        direct = 1'b1;
      end
      PFU_RGB565: begin
        rgb    = {w[PFU_R6_LSB +: 5], 3'h0, w[PFU_G6_LSB +: 6], 2'h0, w[PFU_B_LSB +: 5], 3'h0};
        direct = 1'b1;
      end
      PFU_MIXED: begin
        if (w[PFU_MIX_SEL_BIT]) begin
          lut_idx = w[7:0];
        end else begin
          rgb    = pfu_exp555(w[14:0]);
          direct = 1'b1;
        end
      end
      PFU_TRUE24: begin
        rgb    = {raw[23:16], raw[15:8], raw[7:0]};
        direct = 1'b1;
      end
      default: begin
        lut_idx = 8'h00;
      end
    endcase
  end

endmodule : pfu_pix_decode

// file: pfu_pkg.sv
package pfu_pkg;

  typedef enum logic [2:0] {
    PFU_PLANAR4,
    PFU_PACKED8,
    PFU_RGB555,
    PFU_RGB565,
    PFU_MIXED,
    PFU_TRUE24
  } pfu_fmt_t;

  // memory and palette geometry
  localparam int PFU_PLANES     = 4;
  localparam int PFU_IDX_W      = 8;
  localparam int PFU_DAC_W      = 24;
  localparam int PFU_CPU_AW     = 16;
  localparam int PFU_PAGE_W     = 8;
  localparam int PFU_PAGE_SHIFT = 12;
  localparam int PFU_DISP_AW    = 20;
  localparam int PFU_WORD_BYTES = 4;
  localparam int PFU_Q_BYTES    = 8;
  localparam int PFU_PIX_PER_B  = 8;

  // bytes per pixel for the packed formats
  localparam logic [3:0] PFU_B_PACKED8 = 4'h1;
  localparam logic [3:0] PFU_B_HI      = 4'h2;
  localparam logic [3:0] PFU_B_TRUE    = 4'h3;

  // field positions inside the 16-bit pixel word
  localparam int PFU_MIX_SEL_BIT = 15;
  localparam int PFU_R5_LSB      = 10;
  localparam int PFU_G5_LSB      = 5;
  localparam int PFU_R6_LSB      = 11;
  localparam int PFU_G6_LSB      = 5;
  localparam int PFU_B_LSB       = 0;

  // resolution limits: 800 x 600 and 640 x 480
  localparam logic [10:0] PFU_HI_MAX_H = 11'h320;
  localparam logic [10:0] PFU_HI_MAX_V = 11'h258;
  localparam logic [10:0] PFU_TC_MAX_H = 11'h280;
  localparam logic [10:0] PFU_TC_MAX_V = 11'h1e0;

endpackage : pfu_pkg

// file: pfu_unpacker.sv
`timescale 1ns/100ps
module pfu_unpacker #(
  parameter int DISP_AW = 20
) (
  // clock, reset, enable
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // mode configuration
  input  wire pfu_pkg::pfu_fmt_t    fmt,
  input  wire logic [10:0]          h_size,
  input  wire logic [10:0]          v_size,
  // cpu access
  input  wire logic                 cpu_req,
  input  wire logic                 cpu_we,
  input  wire logic [15:0]          cpu_addr,
  input  wire logic [7:0]           cpu_wdata,
  input  wire logic [7:0]           page_off,
  input  wire logic [3:0]           plane_mask,
  input  wire logic [1:0]           rd_plane,
  output logic [7:0]                cpu_rdata,
  output logic                      cpu_ack,
  // cpu side of display memory
  output logic                      cmem_req,
  output logic                      cmem_we,
  output logic [DISP_AW-1:0]        cmem_addr,
  output logic [3:0]                cmem_be,
  output logic [31:0]               cmem_wdata,
  input  wire logic                 cmem_ack,
  input  wire logic [31:0]          cmem_rdata,
  // display fetch side of display memory
  input  wire logic                 frame_start,
  input  wire logic [DISP_AW-1:0]   scan_base,
  output logic                      dmem_req,
  output logic [DISP_AW-1:0]        dmem_addr,
  input  wire logic                 dmem_ack,
  input  wire logic [31:0]          dmem_rdata,
  // pixel stream to the palette dac
  input  wire logic                 pix_en,
  output logic                      dac_valid,
  output logic                      dac_direct,
  output logic [7:0]                dac_lut_idx,
  output logic [23:0]               dac_rgb,
  output logic                      underrun,
  output logic                      mode_ok
);
  import pfu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check

  if (DISP_AW < PFU_PAGE_W + PFU_PAGE_SHIFT) begin : g_bad_aw
    $error("display address too narrow for the page adder");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [19:0]        map_addr;
  logic [3:0]         map_be;
  logic [1:0]         map_lane;
  logic               cmem_req_r;
  logic               cmem_we_r;
  logic [DISP_AW-1:0] cmem_addr_r;
  logic [3:0]         cmem_be_r;
  logic [31:0]        cmem_wdata_r;
  logic [1:0]         rd_lane_r;
  logic [7:0]         cpu_rdata_r;
  logic               cpu_ack_r;
  logic               cpu_take;

  logic               dmem_req_r;
  logic [DISP_AW-1:0] dmem_addr_r;
  logic [63:0]        acc_r;
  logic [63:0]        acc_nxt;
  logic [3:0]         q_cnt_r;
  logic [3:0]         q_cnt_nxt;
  logic [31:0]        pl_r;
  logic [3:0]         pl_cnt_r;
  logic [3:0]         need;
  logic [3:0]         q_pop;
  logic [3:0]         cnt_pop;
  logic               planar;
  logic               have;
  logic               fire;
  logic               push;
  logic               pl_load;
  logic               fetch_go;
  logic [3:0]         nib;
  logic               mode_ok_r;
  logic               mode_ok_nxt;

  logic [7:0]         dec_idx;
  logic [23:0]        dec_rgb;
  logic               dec_direct;
  logic               dac_valid_r;
  logic               dac_direct_r;
  logic [7:0]         dac_lut_idx_r;
  logic [23:0]        dac_rgb_r;
  logic               underrun_r;

  ////////////////////////////////////////////////////////////////////////////
  // cpu access path

  pfu_cpu_map u_map (
    .fmt        (fmt),
    .cpu_addr   (cpu_addr),
    .page_off   (page_off),
    .plane_mask (plane_mask),
    .rd_plane   (rd_plane),
    .word_addr  (map_addr),
    .lane_en    (map_be),
    .rd_lane    (map_lane)
  );

  // a request while one is open is dropped; cpu waits for cpu_ack
  assign cpu_take = cpu_req && !cmem_req_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmem_req_r   <= 1'b0;
      cmem_we_r    <= 1'b0;
      cmem_addr_r  <= '0;
      cmem_be_r    <= 4'h0;
      cmem_wdata_r <= 32'h00000000;
      rd_lane_r    <= 2'h0;
    end else if (ce) begin
      if (cpu_take) begin
        cmem_req_r   <= 1'b1;
        cmem_we_r    <= cpu_we;
        cmem_addr_r  <= DISP_AW'(map_addr);
        cmem_be_r    <= map_be;
        cmem_wdata_r <= {PFU_PLANES{cpu_wdata}};
        rd_lane_r    <= map_lane;
      end else if (cmem_req_r && cmem_ack) begin
        cmem_req_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ack_r   <= 1'b0;
      cpu_rdata_r <= 8'h00;
    end else if (ce) begin
      cpu_ack_r <= cmem_req_r && cmem_ack;
      if (cmem_req_r && cmem_ack && !cmem_we_r) begin
        cpu_rdata_r <= cmem_rdata[{rd_lane_r, 3'b000} +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode limits

  always_comb begin
    unique case (fmt)
      PFU_RGB555, PFU_RGB565, PFU_MIXED: begin
        mode_ok_nxt = (h_size <= PFU_HI_MAX_H) && (v_size <= PFU_HI_MAX_V);
      end
      PFU_TRUE24: begin
        mode_ok_nxt = (h_size <= PFU_TC_MAX_H) && (v_size <= PFU_TC_MAX_V);
      end
      PFU_PLANAR4, PFU_PACKED8: begin
        mode_ok_nxt = 1'b1;
      end
      default: begin
        mode_ok_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_ok_r <= 1'b0;
    end else if (ce) begin
      mode_ok_r <= mode_ok_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte queue and planar shifter

  assign planar = (fmt == PFU_PLANAR4);

  always_comb begin
    unique case (fmt)
      PFU_PACKED8: need = PFU_B_PACKED8;
      PFU_TRUE24:  need = PFU_B_TRUE;
      default:     need = PFU_B_HI;
    endcase
  end

  assign have    = planar ? (pl_cnt_r != 4'h0) : (q_cnt_r >= need);
  assign fire    = pix_en && have;
  assign push    = dmem_req_r && dmem_ack;
  assign q_pop   = (fire && !planar) ? need : 4'h0;
  assign cnt_pop = q_cnt_r - q_pop;
  // planar keeps one spare word queued behind the shifter
  assign pl_load = planar && (q_cnt_r == 4'(PFU_WORD_BYTES)) &&
                   ((pl_cnt_r == 4'h0) || (fire && pl_cnt_r == 4'h1));

  always_comb begin
    acc_nxt   = acc_r >> {q_pop, 3'b000};
    q_cnt_nxt = cnt_pop;
    if (pl_load) begin
      // word moved to the shifter; stale bits would merge into the next fetch
      acc_nxt   = 64'h0000000000000000;
      q_cnt_nxt = 4'h0;
    end
    if (push) begin
      // oldest byte sits lowest, so blue of a true-colour pixel leads
      acc_nxt   = acc_nxt | ({32'h00000000, dmem_rdata} << {cnt_pop, 3'b000});
      q_cnt_nxt = cnt_pop + 4'(PFU_WORD_BYTES);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_r   <= 64'h0000000000000000;
      q_cnt_r <= 4'h0;
    end else if (ce) begin
      if (frame_start) begin
        acc_r   <= 64'h0000000000000000;
        q_cnt_r <= 4'h0;
      end else begin
        acc_r   <= acc_nxt;
        q_cnt_r <= q_cnt_nxt;
      end
    end
  end

  // plane 3 gives the nibble msb; leftmost pixel is bit 7
  assign nib = {pl_r[31], pl_r[23], pl_r[15], pl_r[7]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pl_r     <= 32'h00000000;
      pl_cnt_r <= 4'h0;
    end else if (ce) begin
      if (frame_start) begin
        pl_cnt_r <= 4'h0;
      end else if (pl_load) begin
        pl_r     <= acc_r[31:0];
        pl_cnt_r <= 4'(PFU_PIX_PER_B);
      end else if (fire && planar) begin
        pl_r     <= (pl_r << 1) & 32'hfefefefe;
        pl_cnt_r <= pl_cnt_r - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display fetch

  // room for a whole word even if nothing is popped this cycle
  assign fetch_go = !dmem_req_r && (planar ? (q_cnt_r == 4'h0) : (q_cnt_r <= 4'h4));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dmem_req_r  <= 1'b0;
      dmem_addr_r <= '0;
    end else if (ce) begin
      if (frame_start) begin
        dmem_req_r  <= 1'b0;
        dmem_addr_r <= scan_base;
      end else if (push) begin
        dmem_req_r  <= 1'b0;
        dmem_addr_r <= dmem_addr_r + DISP_AW'(1);
      end else if (fetch_go) begin
        dmem_req_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel decode and dac register

  pfu_pix_decode u_dec (
    .fmt     (fmt),
    .raw     (acc_r[23:0]),
    .nib     (nib),
    .lut_idx (dec_idx),
    .rgb     (dec_rgb),
    .direct  (dec_direct)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_valid_r   <= 1'b0;
      dac_direct_r  <= 1'b0;
      dac_lut_idx_r <= 8'h00;
      dac_rgb_r     <= 24'h000000;
      underrun_r    <= 1'b0;
    end else if (ce) begin
      dac_valid_r <= fire;
      underrun_r  <= pix_en && !have;
      // an oversize direct mode blanks rather than showing garbage
      if (fire && mode_ok_r) begin
        dac_direct_r  <= dec_direct;
        dac_lut_idx_r <= dec_idx;
        dac_rgb_r     <= dec_rgb;
      end else begin
        dac_direct_r  <= 1'b0;
        dac_lut_idx_r <= 8'h00;
        dac_rgb_r     <= 24'h000000;
      end
    end
  end

  assign cpu_rdata   = cpu_rdata_r;
  assign cpu_ack     = cpu_ack_r;
  assign cmem_req    = cmem_req_r;
  assign cmem_we     = cmem_we_r;
  assign cmem_addr   = cmem_addr_r;
  assign cmem_be     = cmem_be_r;
  assign cmem_wdata  = cmem_wdata_r;
  assign dmem_req    = dmem_req_r;
  assign dmem_addr   = dmem_addr_r;
  assign dac_valid   = dac_valid_r;
  assign dac_direct  = dac_direct_r;
  assign dac_lut_idx = dac_lut_idx_r;
  assign dac_rgb     = dac_rgb_r;
  assign underrun    = underrun_r;
  assign mode_ok     = mode_ok_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_fire(pfu_fmt_t f);
    ce && fire && mode_ok_r && fmt == f;
  endsequence

  sequence s_cpu_take;
    ce && cpu_take;
  endsequence

  property p_planar_bits;
    s_fire(PFU_PLANAR4) |=> dac_lut_idx == {4'h0, $past(nib)} && !dac_direct;
  endproperty
  a_planar_bits: assert property (p_planar_bits) else $error("planar nibble wrong");

  property p_planar_load;
    ce && pl_load |=> pl_cnt_r == 4'h8 && pl_r == $past(acc_r[31:0]);
  endproperty
  a_planar_load: assert property (p_planar_load) else $error("planar load wrong");

  property p_planar_cpu;
    s_cpu_take ##0 fmt == PFU_PLANAR4 |=> cmem_req && cmem_be == $past(plane_mask) &&
      cmem_addr == DISP_AW'($past({4'h0, cpu_addr} + {page_off, 12'h000}));
  endproperty
  a_planar_cpu: assert property (p_planar_cpu) else $error("planar cpu map wrong");

  property p_packed_idx;
    s_fire(PFU_PACKED8) |=> dac_lut_idx == $past(acc_r[7:0]) && !dac_direct;
  endproperty
  a_packed_idx: assert property (p_packed_idx) else $error("packed index wrong");

  property p_packed_cpu;
    s_cpu_take ##0 fmt != PFU_PLANAR4 |=> cmem_be == 4'(4'h1 << $past(cpu_addr[1:0]));
  endproperty
  a_packed_cpu: assert property (p_packed_cpu) else $error("byte lane wrong");

  property p_rgb555;
    s_fire(PFU_RGB555) |=> dac_direct && dac_rgb[23:19] == $past(acc_r[14:10]) &&
      dac_rgb[18:16] == 3'h0 && dac_rgb[7:3] == $past(acc_r[4:0]);
  endproperty
  a_rgb555: assert property (p_rgb555) else $error("555 decode wrong");

  property p_rgb565;
    s_fire(PFU_RGB565) |=> dac_direct && dac_rgb[15:10] == $past(acc_r[10:5]) &&
      dac_rgb[23:19] == $past(acc_r[15:11]);
  endproperty
  a_rgb565: assert property (p_rgb565) else $error("565 decode wrong");

  property p_mixed_lut;
    s_fire(PFU_MIXED) ##0 acc_r[15] |=> !dac_direct && dac_lut_idx == $past(acc_r[7:0]);
  endproperty
  a_mixed_lut: assert property (p_mixed_lut) else $error("mixed index wrong");

  property p_mixed_rgb;
    s_fire(PFU_MIXED) ##0 !acc_r[15] |=> dac_direct && dac_rgb[23:19] == $past(acc_r[14:10]);
  endproperty
  a_mixed_rgb: assert property (p_mixed_rgb) else $error("mixed colour wrong");

  property p_true24;
    s_fire(PFU_TRUE24) ##0 !push |=> dac_direct && dac_rgb == $past(acc_r[23:0]) &&
      q_cnt_r == $past(q_cnt_r) - 4'h3;
  endproperty
  a_true24: assert property (p_true24) else $error("true colour wrong");

  property p_blank;
    ce && fire && !mode_ok_r |=> dac_rgb == 24'h000000 && !dac_direct;
  endproperty
  a_blank: assert property (p_blank) else $error("oversize mode not blanked");

endmodule : pfu_unpacker

// file: pfu_unpacker_test.sv
`timescale 1ns/100ps
module pfu_unpacker_test;
  import pfu_pkg::*;
  logic        clk_sys = 0, rst_n = 0, ce = 1, cpu_req = 0, cpu_we = 0;
  logic        frame_start = 0, pix_en = 0;
  pfu_fmt_t    fmt = PFU_PLANAR4;
  logic [10:0] h_size = 11'h280, v_size = 11'h1e0;
  logic [15:0] cpu_addr = 16'h0;
  logic [7:0]  cpu_wdata = 8'h0, page_off = 8'h0, cpu_rdata, dac_lut_idx;
  logic [3:0]  plane_mask = 4'hf, cmem_be;
  logic [1:0]  rd_plane = 2'h0, lag = 2'h0;
  logic [19:0] scan_base = 20'h0, cmem_addr, dmem_addr;
  logic [31:0] cmem_wdata, cmem_rdata, dmem_rdata;
  logic        cpu_ack, cmem_req, cmem_we, cmem_ack, dmem_req, dmem_ack;
  logic        dac_valid, dac_direct, underrun, mode_ok;
  logic [23:0] dac_rgb;
  logic [32:0] got[$];
  logic        ce_q = 1'b1;
  int          checks = 0, miscompares = 0, und = 0, base = 0;

  always #50 clk_sys = ~clk_sys;

  pfu_unpacker dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .fmt(fmt),
    .h_size(h_size), .v_size(v_size), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .page_off(page_off),
    .plane_mask(plane_mask), .rd_plane(rd_plane), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack), .cmem_req(cmem_req), .cmem_we(cmem_we), .cmem_addr(cmem_addr),
    .cmem_be(cmem_be), .cmem_wdata(cmem_wdata), .cmem_ack(cmem_ack),
    .cmem_rdata(cmem_rdata), .frame_start(frame_start), .scan_base(scan_base),
    .dmem_req(dmem_req), .dmem_addr(dmem_addr), .dmem_ack(dmem_ack),
    .dmem_rdata(dmem_rdata), .pix_en(pix_en), .dac_valid(dac_valid),
    .dac_direct(dac_direct), .dac_lut_idx(dac_lut_idx), .dac_rgb(dac_rgb),
    .underrun(underrun), .mode_ok(mode_ok));

  pfu_mem_model mem_u (.clk_sys(clk_sys), .lag(lag), .cmem_req(cmem_req),
    .cmem_we(cmem_we), .cmem_addr(cmem_addr), .cmem_be(cmem_be),
    .cmem_wdata(cmem_wdata), .cmem_ack(cmem_ack), .cmem_rdata(cmem_rdata),
    .dmem_req(dmem_req), .dmem_addr(dmem_addr), .dmem_ack(dmem_ack),
    .dmem_rdata(dmem_rdata));

  // outputs stand one cycle; an edge with ce low repeats them, so skip it
  always @(posedge clk_sys) ce_q <= ce;

  always @(negedge clk_sys) begin
    if (ce_q && dac_valid === 1'b1) got.push_back({dac_direct, dac_lut_idx, dac_rgb});
    if (ce_q && underrun === 1'b1) und++;
  end

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  function automatic logic [7:0] byt(int j);
    return mem_u.mem[(base + j / 4) % 256][8*(j%4)+:8];
  endfunction : byt

  // {direct, index, rgb} worked out from memory contents
  function automatic logic [32:0] exp_pix(pfu_fmt_t f, int k);
    logic [15:0] w;
    logic [3:0]  n;
    logic [23:0] r5;
    w = {byt(2 * k + 1), byt(2 * k)};
    r5 = {w[14:10], 3'h0, w[9:5], 3'h0, w[4:0], 3'h0};
    for (int p = 0; p < 4; p++) n[p] = mem_u.mem[(base + k / 8) % 256][8*p+7-k%8];
    case (f)
      PFU_PLANAR4: return {1'b0, 4'h0, n, 24'h0};
      PFU_PACKED8: return {1'b0, byt(k), 24'h0};
      PFU_RGB555:  return {1'b1, 8'h0, r5};
      PFU_RGB565:  return {1'b1, 8'h0, w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0};
      PFU_MIXED:   return w[15] ? {1'b0, w[7:0], 24'h0} : {1'b1, 8'h0, r5};
      default:     return {1'b1, 8'h0, byt(3 * k + 2), byt(3 * k + 1), byt(3 * k)};
    endcase
  endfunction : exp_pix

  // sixteen pixels with random gaps in demand and a random memory lag
  task automatic run_fmt(input pfu_fmt_t f);
    logic [32:0] e;
    int          t;
    @(negedge clk_sys);
    fmt = f;
    base = $urandom_range(15);
    scan_base = 20'(base);
    lag = 2'($urandom_range(2));
    frame_start = 1'b1;
    if (f == PFU_MIXED) begin
      mem_u.mem[base][15] = 1'b1;
      mem_u.mem[base][31] = 1'b0;
    end
    @(negedge clk_sys);
    frame_start = 1'b0;
    pix_en = 1'b1;
    got.delete();
    for (t = 0; t < 2000 && got.size() < 16; t++) begin
      @(negedge clk_sys);
      pix_en = 1'($urandom_range(1));
      ce = ($urandom_range(3) != 0);
    end
    pix_en = 1'b0;
    ce = 1'b1;
    check(got.size() >= 16, 1);
    for (int k = 0; k < 16 && k < got.size(); k++) begin
      e = exp_pix(f, k);
      check(got[k][32], e[32]);
      if (e[32]) check(got[k][23:0], e[23:0]);
      else check(got[k][31:24], e[31:24]);
    end
    $display("test stream fmt %0d done", f);
  endtask : run_fmt

  task automatic mode_case(input pfu_fmt_t f, input logic [10:0] h, v, input logic ok);
    @(negedge clk_sys);
    fmt = f;
    h_size = h;
    v_size = v;
    repeat (2) @(negedge clk_sys);
    check(mode_ok, ok);
    if (!ok) begin
      pix_en = 1'b1;
      @(negedge clk_sys);
      pix_en = 1'b0;
      check(dac_valid, 1);
      check({dac_direct, dac_rgb}, 25'h0);
    end
  endtask : mode_case

  task automatic cpu_op(input logic we, output logic [19:0] ad, output logic [3:0] be);
    int t;
    repeat (2) @(negedge clk_sys);
    cpu_req = 1'b1;
    cpu_we = we;
    @(negedge clk_sys);
    cpu_req = 1'b0;
    ad = cmem_addr;
    be = cmem_be;
    for (t = 0; t < 20 && cpu_ack !== 1'b1; t++) @(negedge clk_sys);
    check(cpu_ack, 1);
  endtask : cpu_op

  ////////////////////////////////////////
  initial begin
    logic [19:0] ad, disp;
    logic [3:0]  be;
    void'($urandom(47228));
    for (int i = 0; i < 256; i++) mem_u.mem[i] = $urandom;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    run_fmt(PFU_PLANAR4);
    check(und > 0, 1);
    run_fmt(PFU_PACKED8);
    run_fmt(PFU_RGB555);
    run_fmt(PFU_RGB565);
    run_fmt(PFU_MIXED);
    run_fmt(PFU_TRUE24);
    mode_case(PFU_RGB565, 11'h320, 11'h258, 1);
    mode_case(PFU_RGB555, 11'h321, 11'h258, 0);
    mode_case(PFU_TRUE24, 11'h280, 11'h1e0, 1);
    mode_case(PFU_TRUE24, 11'h280, 11'h1e1, 0);
    mode_case(pfu_fmt_t'(3'h6), 11'h280, 11'h1e0, 0);
    $display("test mode limits done");
    // first pass of each format hits the top of the window and page, where the adder wraps
    for (int i = 0; i < 12; i++) begin
      fmt = (i < 6) ? PFU_PACKED8 : PFU_PLANAR4;
      cpu_addr = (i % 6 == 0) ? 16'hffff : 16'($urandom);
      page_off = (i % 6 == 0) ? 8'hff : 8'($urandom);
      cpu_wdata = 8'($urandom);
      rd_plane = 2'($urandom);
      plane_mask = 4'($urandom) | (4'h1 << rd_plane);
      disp = {4'h0, cpu_addr} + {page_off, 12'h0};
      cpu_op(1'b1, ad, be);
      if (i < 6) begin
        check(ad, disp >> 2);
        check(be, 4'h1 << disp[1:0]);
        check(cmem_wdata, {4{cpu_wdata}});
      end else begin
        check(ad, disp);
        check(be, plane_mask);
      end
      cpu_op(1'b0, ad, be);
      check(cpu_rdata, cpu_wdata);
    end
    $display("test cpu access done");
    close_out();
  end

  initial begin
    #(100 * 50000);
    miscompares++;
    close_out();
  end
endmodule : pfu_unpacker_test
